// file: bcw_kbd_model.sv
`timescale 1ns/100ps
module bcw_kbd_model
    import bcw_pkg::*;
(
    input  wire logic       mclk,
    output logic            rxValid,
    output logic      [7:0] rxByte,
    output logic            rxParityErr,
    output logic            keyboardClockLine,
    output logic            byteInProgress
);
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h5A;
        rxParityErr = 1'b0;
        keyboardClockLine = 1'b1;
        byteInProgress = 1'b0;
    end
    // ----------------------------------------
    // Frame: eleven bits, clock idles high
    // ----------------------------------------
    task automatic send(input logic [7:0] b, input logic perr);
        int k;
        @(posedge mclk);
        byteInProgress <= 1'b1;
        for (k = 0; k < 22; k++) begin
            keyboardClockLine <= ~keyboardClockLine;
            @(posedge mclk);
        end
        rxValid <= 1'b1;
        rxByte <= b;
        rxParityErr <= perr;
        byteInProgress <= 1'b0;
        @(posedge mclk);
        rxValid <= 1'b0;
        rxByte <= ~b; // Released data must not look valid
        rxParityErr <= ~perr;
    endtask
    // Clock held low mid-byte, long enough to trip the timeout
    task automatic stall();
        @(posedge mclk);
        byteInProgress <= 1'b1;
        keyboardClockLine <= 1'b0;
        repeat (TIMEOUT_CYC + 16) @(posedge mclk);
        byteInProgress <= 1'b0;
        keyboardClockLine <= 1'b1;
    endtask
endmodule

// file: bcw_matcher.sv
`timescale 1ns/100ps
module bcw_matcher
    import bcw_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    input  wire logic       rxValid,
    input  wire logic [7:0] rxByte,
    input  wire logic       rxParityErr,
    input  wire logic       keyboardClockLine,
    input  wire logic       byteInProgress,
    input  wire logic       makeDetect,
    output logic            keyWakeEvent,
    output logic            wakeRaise
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    bcw_regs_if rif ();
    bcw_state_t state_q, state_d;
    logic       event_q, event_d;
    logic [TMO_W-1:0] tmo_q, tmo_d;
    logic       kclkPrev_q;
    logic       raise_q, raise_d;

    bcw_regs u_regs (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .regAddr    (regAddr),
        .regWdata   (regWdata),
        .regWr      (regWr),
        .regRd      (regRd),
        .statusBits ({state_q != ST_B1, event_q}),
        .regRdata   (regRdata),
        .rif        (rif)
    );

    // ------------------------------------------------------------
    // Timeout on a stuck clock line inside a byte
    // ------------------------------------------------------------
    logic timeout;
    always_comb begin
        tmo_d = '0;
        if (byteInProgress && keyboardClockLine == kclkPrev_q) begin
            if (tmo_q != TMO_W'(TIMEOUT_CYC))
                tmo_d = tmo_q + 1'b1;
            else
                tmo_d = tmo_q;
        end
    end
    assign timeout = (tmo_q == TMO_W'(TIMEOUT_CYC - 1));

    // ------------------------------------------------------------
    // Break-code matcher
    // ------------------------------------------------------------
    logic       validByte;
    logic       hit1, hit2, hit3;
    logic       breakMode;
    logic [1:0] nBytes;
    assign validByte = rxValid && !rxParityErr;
    // Zero stored means any valid byte matches
    assign hit1 = (rif.cmp1 == WILDCARD) || (rxByte == rif.cmp1);
    assign hit2 = (rif.cmp2 == WILDCARD) || (rxByte == rif.cmp2);
    assign hit3 = (rif.cmp3 == WILDCARD) || (rxByte == rif.cmp3);
    assign breakMode = (rif.relSel == REL_BREAK);

    always_comb begin
        unique case (rif.scanSel)
            SEL_S1_ONE: nBytes = 2'd1;
            SEL_S1_TWO: nBytes = 2'd2;
            SEL_S2_TWO: nBytes = 2'd2;
            SEL_S2_THR: nBytes = 2'd3;
        endcase
    end

    always_comb begin
        state_d = state_q;
        event_d = event_q;
        raise_d = 1'b0;
        if (!event_q) begin
            state_d = ST_B1;
            if (makeDetect && breakMode) begin
                event_d = 1'b1;
                raise_d = 1'b1;
            end
        end else if (!breakMode) begin
            // Other release options are not implemented; the event stays held
            state_d = ST_B1;
        end else if (timeout || (rxValid && rxParityErr)) begin
            state_d = ST_B1;
        end else if (validByte) begin
            // makeDetect ignored while held: no new events
            unique case (state_q)
                ST_B1: begin
                    if (hit1 && nBytes == 2'd1)
                        event_d = 1'b0;
                    else if (hit1)
                        state_d = ST_B2;
                end
                ST_B2: begin
                    // validByte already guards the final byte
                    if (hit2 && nBytes == 2'd2) begin
                        event_d = 1'b0;
                        state_d = ST_B1;
                    end else if (hit2)
                        state_d = ST_B3;
                    else
                        state_d = ST_B1;
                end
                ST_B3: begin
                    if (hit3)
                        event_d = 1'b0;
                    state_d = ST_B1;
                end
                default: state_d = ST_B1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_B1;
            event_q    <= 1'b0;
            tmo_q      <= '0;
            kclkPrev_q <= 1'b1;
            raise_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            event_q    <= event_d;
            tmo_q      <= tmo_d;
            kclkPrev_q <= keyboardClockLine;
            raise_q    <= raise_d;
        end
    end

    // Active low wake level; status reads event_q live, and event_q is cleared here on a matched break
    assign keyWakeEvent = !event_q;
    assign wakeRaise    = raise_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_one_byte;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && breakMode && !timeout && validByte && hit1 && nBytes == 2'd1 && state_q == ST_B1)
            |=> keyWakeEvent;
    endproperty
    a_one_byte: assert property (p_one_byte) else $error("one byte break not released");

    property p_two_byte;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && breakMode && !timeout && validByte && state_q == ST_B2 && hit2 && nBytes == 2'd2)
            |=> (keyWakeEvent && state_q == ST_B1);
    endproperty
    a_two_byte: assert property (p_two_byte) else $error("two byte break not released");

    property p_three_byte;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && state_q == ST_B3 && breakMode && !timeout && validByte && !hit3) |=> event_q;
    endproperty
    a_three_byte: assert property (p_three_byte) else $error("released on third mismatch");

    property p_parity_final;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && rxValid && rxParityErr) |=> (event_q && state_q == ST_B1);
    endproperty
    a_parity_final: assert property (p_parity_final) else $error("parity byte accepted");

    property p_restart;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && state_q != ST_B1 && timeout) |=> state_q == ST_B1;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on timeout");

    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && !validByte && breakMode) |=> event_q;
    endproperty
    a_hold: assert property (p_hold) else $error("event dropped without byte");

    property p_no_raise;
        @(posedge mclk) disable iff (!rst_n)
        event_q |=> !wakeRaise;
    endproperty
    a_no_raise: assert property (p_no_raise) else $error("raise while held");

    property p_idle_first;
        @(posedge mclk) disable iff (!rst_n)
        !event_q |=> state_q == ST_B1;
    endproperty
    a_idle_first: assert property (p_idle_first) else $error("matcher active while idle");

    property p_timeout_count;
        @(posedge mclk) disable iff (!rst_n)
        timeout |-> $past(tmo_q) == TMO_W'(TIMEOUT_CYC - 2);
    endproperty
    a_timeout_count: assert property (p_timeout_count) else $error("timeout count wrong");

    property p_first_miss;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && breakMode && !timeout && validByte && state_q == ST_B1 && !hit1)
            |=> (event_q && state_q == ST_B1);
    endproperty
    a_first_miss: assert property (p_first_miss) else $error("first byte mismatch moved on");

    property p_advance;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && breakMode && !timeout && validByte && state_q == ST_B1 && hit1 && nBytes != 2'd1)
            |=> (event_q && state_q == ST_B2);
    endproperty
    a_advance: assert property (p_advance) else $error("first byte match did not advance");

    property p_second_miss;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && breakMode && !timeout && validByte && state_q == ST_B2 && !hit2)
            |=> (event_q && state_q == ST_B1);
    endproperty
    a_second_miss: assert property (p_second_miss) else $error("second byte mismatch not restarted");

    property p_three_release;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && breakMode && !timeout && validByte && state_q == ST_B3 && hit3)
            |=> (keyWakeEvent && state_q == ST_B1);
    endproperty
    a_three_release: assert property (p_three_release) else $error("three byte break not released");

    // Checked from the stored value, not from the hit term, so a broken compare still shows
    property p_wildcard;
        @(posedge mclk) disable iff (!rst_n)
        (event_q && breakMode && !timeout && validByte && state_q == ST_B2 && rif.cmp2 == WILDCARD
            && nBytes == 2'd2) |=> keyWakeEvent;
    endproperty
    a_wildcard: assert property (p_wildcard) else $error("zero compare did not match");

    // ------------------------------------------------------------
    // Arming, timeout and status checks
    // ------------------------------------------------------------
    property p_raise;
        @(posedge mclk) disable iff (!rst_n)
        (!event_q && makeDetect && breakMode) |=> (!keyWakeEvent && wakeRaise);
    endproperty
    a_raise: assert property (p_raise) else $error("event not raised in break mode");

    property p_no_arm;
        @(posedge mclk) disable iff (!rst_n)
        (!event_q && !breakMode) |=> (keyWakeEvent && !wakeRaise);
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("event raised outside break mode");

    property p_tmo_idle;
        @(posedge mclk) disable iff (!rst_n)
        !byteInProgress |=> (tmo_q == '0 && !timeout);
    endproperty
    a_tmo_idle: assert property (p_tmo_idle) else $error("timeout counted between bytes");

    property p_status_read;
        @(posedge mclk) disable iff (!rst_n)
        (regRd && regAddr == ADDR_STAT)
            |=> (regRdata == {6'h00, ($past(state_q) != ST_B1), $past(event_q)});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    c_one: cover property (@(posedge mclk) disable iff (!rst_n) event_q && nBytes == 2'd1 ##1 !event_q);
    c_two: cover property (@(posedge mclk) disable iff (!rst_n) state_q == ST_B2 && nBytes == 2'd2 ##1 !event_q);
    c_three: cover property (@(posedge mclk) disable iff (!rst_n) state_q == ST_B3 ##1 !event_q);
    c_tmo: cover property (@(posedge mclk) disable iff (!rst_n) state_q != ST_B1 && timeout);
    c_wild: cover property (@(posedge mclk) disable iff (!rst_n) state_q == ST_B2 && rif.cmp2 == WILDCARD && validByte);
endmodule

// file: bcw_pkg.sv
package bcw_pkg;
    localparam logic [7:0] ADDR_BRK1 = 8'h61;
    localparam logic [7:0] ADDR_BRK2 = 8'h62;
    localparam logic [7:0] ADDR_BRK3 = 8'h63;
    localparam logic [7:0] ADDR_CFG  = 8'h64;
    localparam logic [7:0] ADDR_STAT = 8'h65;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] WILDCARD  = 8'h00;
    localparam int SEL_LO = 2;
    localparam int REL_LO = 4;
    localparam logic [1:0] SEL_S1_ONE = 2'h0;
    localparam logic [1:0] SEL_S1_TWO = 2'h1;
    localparam logic [1:0] SEL_S2_TWO = 2'h2;
    localparam logic [1:0] SEL_S2_THR = 2'h3;
    localparam logic [1:0] REL_BREAK  = 2'h2;
    localparam int CLK_MHZ = 25;
    localparam int TIMEOUT_US = 125;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int TMO_W = 12;
    typedef enum logic [2:0] {
        ST_B1 = 3'b001,
        ST_B2 = 3'b010,
        ST_B3 = 3'b100
    } bcw_state_t;
endpackage

// file: bcw_regs.sv
`timescale 1ns/100ps
module bcw_regs
    import bcw_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic [1:0] statusBits,
    output logic      [7:0] regRdata,
    bcw_regs_if.regs        rif
);
    logic [7:0] brk1_q, brk1_d;
    logic [7:0] brk2_q, brk2_d;
    logic [7:0] brk3_q, brk3_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        brk1_d  = brk1_q;
        brk2_d  = brk2_q;
        brk3_d  = brk3_q;
        cfg_d   = cfg_q;
        rdata_d = 8'h00;
        if (regWr) begin
            unique case (regAddr)
                ADDR_BRK1: brk1_d = regWdata;
                ADDR_BRK2: brk2_d = regWdata;
                ADDR_BRK3: brk3_d = regWdata;
                ADDR_CFG:  cfg_d  = regWdata;
                default: ;
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                ADDR_BRK1: rdata_d = brk1_q;
                ADDR_BRK2: rdata_d = brk2_q;
                ADDR_BRK3: rdata_d = brk3_q;
                ADDR_CFG:  rdata_d = cfg_q;
                ADDR_STAT: rdata_d = {6'h00, statusBits};
                default:   rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            brk1_q  <= RST_BYTE;
            brk2_q  <= RST_BYTE;
            brk3_q  <= RST_BYTE;
            cfg_q   <= RST_BYTE;
            rdata_q <= 8'h00;
        end else begin
            brk1_q  <= brk1_d;
            brk2_q  <= brk2_d;
            brk3_q  <= brk3_d;
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign regRdata    = rdata_q;
    assign rif.cmp1    = brk1_q;
    assign rif.cmp2    = brk2_q;
    assign rif.cmp3    = brk3_q;
    assign rif.scanSel = cfg_q[SEL_LO +: 2];
    assign rif.relSel  = cfg_q[REL_LO +: 2];
endmodule

// file: bcw_regs_if.sv
`timescale 1ns/100ps
interface bcw_regs_if;
    logic [7:0] cmp1;
    logic [7:0] cmp2;
    logic [7:0] cmp3;
    logic [1:0] scanSel;
    logic [1:0] relSel;
    modport regs (output cmp1, cmp2, cmp3, scanSel, relSel);
    modport core (input cmp1, cmp2, cmp3, scanSel, relSel);
endinterface

// file: tb.sv
`timescale 1ns/100ps
module tb
    import bcw_pkg::*;
;
    logic       mclk, rst_n, regWr, regRd, makeDetect;
    logic [7:0] regAddr, regWdata, regRdata, v;
    logic       rxValid, rxParityErr, keyboardClockLine, byteInProgress, keyWakeEvent, wakeRaise;
    logic [7:0] rxByte;
    logic [7:0] c[3];
    int         fails, n_checks, s, k;
    bcw_kbd_model kbd (.mclk(mclk), .rxValid(rxValid), .rxByte(rxByte), .rxParityErr(rxParityErr),
        .keyboardClockLine(keyboardClockLine), .byteInProgress(byteInProgress));
    bcw_matcher uut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .rxValid(rxValid), .rxByte(rxByte), .rxParityErr(rxParityErr),
        .keyboardClockLine(keyboardClockLine), .byteInProgress(byteInProgress), .makeDetect(makeDetect),
        .keyWakeEvent(keyWakeEvent), .wakeRaise(wakeRaise));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic int nbytes(input logic [1:0] sel);
        return (sel == SEL_S1_ONE) ? 1 : (sel == SEL_S2_THR) ? 3 : 2;
    endfunction
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    // Pulse make detection; raise count must be exp_r
    task automatic arm(input logic [1:0] sel, input logic [1:0] rel, input logic ev, input int exp_r);
        int r;
        r = 0;
        wr(ADDR_CFG, {2'h0, rel, sel, 2'h0});
        @(posedge mclk);
        makeDetect <= 1'b1;
        @(posedge mclk);
        makeDetect <= 1'b0;
        repeat (3) begin
            #1 r += int'(wakeRaise === 1'b1);
            @(posedge mclk);
        end
        chk(8'(r), 8'(exp_r));
        #1 chk({7'h0, keyWakeEvent}, {7'h0, ev});
    endtask
    task automatic held(input logic ev);
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, keyWakeEvent}, {7'h0, ev});
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        print_verdict();
    end
    initial begin
        {rst_n, regWr, regRd, makeDetect, regAddr, regWdata} = '0;
        void'($urandom(32'hEC175053));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (k = 0; k < 4; k++) begin
            rd(ADDR_BRK1 + 8'(k), v);
            chk(v, RST_BYTE);
        end
        wr(8'h70, 8'($urandom));
        rd(8'h70, v);
        chk(v, 8'h00);
        for (s = 0; s < 4; s++) begin
            for (k = 0; k < 3; k++) begin
                c[k] = {4'(k + 1), 4'($urandom)};
                wr(ADDR_BRK1 + 8'(k), c[k]);
                rd(ADDR_BRK1 + 8'(k), v);
                chk(v, c[k]);
            end
            arm(2'(s), REL_BREAK, 1'b0, 1);
            for (k = 0; k < nbytes(2'(s)) - 1; k++) kbd.send(c[k], 1'b0);
            kbd.send(c[nbytes(2'(s)) - 1], 1'b1);
            held(1'b0);
            for (k = 0; k < nbytes(2'(s)); k++) begin
                kbd.send(c[k], 1'b0);
                held(k == nbytes(2'(s)) - 1);
            end
        end
        arm(SEL_S2_THR, REL_BREAK, 1'b0, 1);
        arm(SEL_S2_THR, REL_BREAK, 1'b0, 0);
        kbd.send(c[0], 1'b0);
        kbd.send(c[1] ^ 8'hFF, 1'b0);
        kbd.send(c[2], 1'b0);
        kbd.send(c[0], 1'b0);
        kbd.stall();
        kbd.send(c[1], 1'b0);
        kbd.send(c[2], 1'b0);
        held(1'b0);
        for (k = 0; k < 3; k++) kbd.send(c[k], 1'b0);
        held(1'b1);
        arm(SEL_S2_THR, REL_BREAK, 1'b0, 1);
        kbd.send(c[0], 1'b0);
        kbd.send(c[1], 1'b0);
        kbd.send(c[2] ^ 8'hFF, 1'b0);
        held(1'b0);
        kbd.send(c[0], 1'b0);
        rd(ADDR_STAT, v);
        chk(v, 8'h03);
        kbd.send(c[1], 1'b0);
        kbd.send(c[2], 1'b0);
        held(1'b1);
        rd(ADDR_STAT, v);
        chk(v, 8'h00);
        wr(ADDR_BRK2, WILDCARD);
        arm(SEL_S1_TWO, REL_BREAK, 1'b0, 1);
        kbd.send(c[0], 1'b0);
        kbd.send(8'($urandom), 1'b0);
        held(1'b1);
        arm(SEL_S1_ONE, 2'h0, 1'b1, 0);
        print_verdict();
    end
endmodule
